// File: common/pmc_map.svh
/*
 * register offsets, field positions, reset values, mode codes and timing
 * figures of the power-mode clock controller.
 * assumes: included by bare name, definitions only.
 */
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PMC_OFS_PLL 4'h0
`define PMC_OFS_DIV 4'h4
`define PMC_OFS_VREG 4'h8
`define PMC_OFS_MODE 4'hc

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PMC_PLL_MULT 6:0
`define PMC_DIV_SYS 3:0
`define PMC_DIV_CORE 5:4
`define PMC_VREG_HIB_N 0
`define PMC_VREG_XCLK_EN 1
`define PMC_VREG_XCLK_BUF 2
`define PMC_MODE_CODE 2:0
`define PMC_MODE_PG 3
`define PMC_MODE_BUSY 4

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define PMC_MULT_RST 7'h06
`define PMC_MULT_MIN 7'h05
`define PMC_MULT_MAX 7'h40
`define PMC_SSEL_RST 4'h5
`define PMC_CSEL_RST 2'h0
`define PMC_SSEL_BAD 4'h0

// ----------------------------------------------------------------------
// mode codes, read from the mode register; all but PMC_M_HIB can be written to it
// ----------------------------------------------------------------------
`define PMC_M_FULL 3'h0
`define PMC_M_ACTIVE 3'h1
`define PMC_M_SLEEP 3'h2
`define PMC_M_DEEP 3'h3
`define PMC_M_HIB 3'h4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PMC_CLK_NS 50
`define PMC_WAKE_MIN_NS 10
`define PMC_SETTLE_NS 200
`define PMC_SETTLE_CYC ((`PMC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)

`endif

// File: common/pmc_pkg.sv
/*
 * types shared by the power-mode clock controller.
 * assumes: pmc_map.svh on the include path.
 */
package pmc_pkg;
    // clock generator settings handed to the pll and divider cells
    typedef struct packed {
        logic pll_en;
        logic pll_bypass;
        logic [6:0] mult;
        logic [3:0] sys_div;
        logic [3:0] core_div;
    } pmc_clk_cfg_t;

    typedef enum logic [1:0] {
        S_PGWAIT,
        S_RUN,
        S_SWITCH,
        S_HIB
    } pmc_state_t;
endpackage

// File: core/pmc_ctrl.sv
/*
 * power-mode and clock-generation controller: mode sequencer, pll and
 * divider settings, clock gates, regulator wake, clock output pin, and an
 * avalon-mm register slave.
 * assumes: analog pll and dividers outside take clk_cfg_o; pins and the
 * wake source are asynchronous; por_n_i falls only when the io supply
 * itself comes up.
 */
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "pmc_map.svh"

// Notes on behaviour
// RULE1: after power-up run full-on: pll enabled, not bypassed, both clocks on.
// RULE2: active mode keeps pll enabled but bypassed; clocks run at input rate.
// RULE3: active mode permits dma into suitably configured level-one memory.
// RULE4: sleep gates the core clock only; pll and system clock keep running.
// RULE5: sleep refuses system dma into level-one memory.
// RULE6: deep sleep gates both clocks and blocks asynchronous peripherals.
// RULE7: deep sleep ends only on reset or a gpio wake. Code also leaves it when the hibernate bit is cleared.
// RULE8: a gpio wake level lasting the minimum time is always caught.
// RULE9: clearing the hibernate bit gates clocks and drops regulator wake.
// RULE10: hibernation three-states the external pins.
// RULE11: regulator control register survives hibernation; all else is lost.
// RULE12: regulator wake is high for power present, low for shutdown.
// RULE13: reset during hibernation raises regulator wake, then boots.
// RULE14: after a wake-up, start waits for power-good low.
// RULE15: pll multiplier 5 to 64, six after reset.
// RULE16: core and system clocks both derive from the input clock.
// RULE17: system divider 1 to 15 from its binary code.
// RULE18: core divider codes select ratios 1, 2, 4, 8.
// RULE19: divider writes apply at once, with no relock wait.
// RULE20: clock pin outputs system clock or buffered input clock.
// RULE21: clock pin three-stated after reset until software enables it.
// RULE22: mode changes only on request and finish before new gating.
module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYC = `PMC_SETTLE_CYC
)
(
    // clock and resets
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // asynchronous pins
    input wire logic gpio_wake_i,
    input wire logic power_good_n_i,
    // clock generation and gating
    output pmc_clk_cfg_t clk_cfg_o,
    output logic core_clk_en_o,
    output logic sys_clk_en_o,
    // system side
    output logic dma_l1_allow_o,
    output logic async_block_o,
    output logic pins_hiz_o,
    // regulator and clock output pin
    output logic regulator_wake_out_o,
    output logic xclk_buf_sel_o,
    output logic xclk_oe_n_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pmc_state_t state_reg;
    logic [2:0] mode_reg;
    logic [2:0] target_reg;
    logic [7:0] settle_reg;
    logic [6:0] mult_reg;
    logic [3:0] ssel_reg;
    logic [1:0] csel_reg;
    logic hib_n_reg;
    logic xclk_en_reg;
    logic xclk_buf_reg;
    logic hib_ret_reg;
    logic wait_reg;
    logic wake_tgl_reg;
    logic [2:0] wake_sync_reg;
    logic [2:0] pg_sync_reg;
    logic pg_ok_reg;
    logic wake_seen_reg;
    logic bus_wr;
    logic bus_rd;
    logic mode_wr;
    logic [2:0] mode_wcode;
    logic mode_code_ok;
    logic wake_ev;
    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, answer on the second edge
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i)
        wait_reg <= !rst_n_i || !((avs_read_i || avs_write_i) && wait_reg);
    assign bus_wr = avs_write_i && !wait_reg;
    assign bus_rd = avs_read_i && wait_reg;
    assign avs_waitrequest_o = wait_reg;
    assign mode_wcode = avs_writedata_i[`PMC_MODE_CODE];
    assign mode_wr = bus_wr && (avs_address_i == `PMC_OFS_MODE);
    assign mode_code_ok = (mode_wcode <= `PMC_M_DEEP);
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            avs_readdata_o <= 32'h0;
        else if (bus_rd)
        begin
            avs_readdata_o <= 32'h0;
            unique case (avs_address_i)
                `PMC_OFS_PLL:
                    avs_readdata_o[`PMC_PLL_MULT] <= mult_reg;
                `PMC_OFS_DIV:
                begin
                    avs_readdata_o[`PMC_DIV_SYS] <= ssel_reg;
                    avs_readdata_o[`PMC_DIV_CORE] <= csel_reg;
                end
                `PMC_OFS_VREG:
                begin
                    avs_readdata_o[`PMC_VREG_HIB_N] <= hib_n_reg;
                    avs_readdata_o[`PMC_VREG_XCLK_EN] <= xclk_en_reg;
                    avs_readdata_o[`PMC_VREG_XCLK_BUF] <= xclk_buf_reg;
                end
                `PMC_OFS_MODE:
                begin
                    avs_readdata_o[`PMC_MODE_CODE] <= mode_reg;
                    avs_readdata_o[`PMC_MODE_PG] <= pg_ok_reg;
                    avs_readdata_o[`PMC_MODE_BUSY] <= (state_reg != S_RUN);
                end
                default:
                    avs_readdata_o <= 32'h0;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // pll and divider settings
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            mult_reg <= `PMC_MULT_RST; // RULE15
            ssel_reg <= `PMC_SSEL_RST;
            csel_reg <= `PMC_CSEL_RST;
        end
        else if (bus_wr)
        begin
            // out-of-range values are dropped, the old setting stays
            if (avs_address_i == `PMC_OFS_PLL
                && avs_writedata_i[`PMC_PLL_MULT] >= `PMC_MULT_MIN
                && avs_writedata_i[`PMC_PLL_MULT] <= `PMC_MULT_MAX)
                mult_reg <= avs_writedata_i[`PMC_PLL_MULT]; // RULE15
            if (avs_address_i == `PMC_OFS_DIV)
            begin
                if (avs_writedata_i[`PMC_DIV_SYS] != `PMC_SSEL_BAD)
                    ssel_reg <= avs_writedata_i[`PMC_DIV_SYS]; // RULE17
                csel_reg <= avs_writedata_i[`PMC_DIV_CORE]; // RULE18
            end
        end
    end
    // ------------------------------------------------------------------
    // regulator control: the io-supply reset sets hib_n_reg and clears the other bits; the system reset only sets hib_n_reg
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!por_n_i)
        begin
            hib_n_reg <= 1'b1;
            xclk_en_reg <= 1'b0; // RULE21
            xclk_buf_reg <= 1'b0;
            hib_ret_reg <= 1'b0;
        end
        else if (!rst_n_i)
            hib_n_reg <= 1'b1; // RULE11 RULE13
        else
        begin
            if (bus_wr && avs_address_i == `PMC_OFS_VREG)
            begin
                hib_n_reg <= avs_writedata_i[`PMC_VREG_HIB_N]; // RULE9
                xclk_en_reg <= avs_writedata_i[`PMC_VREG_XCLK_EN];
                xclk_buf_reg <= avs_writedata_i[`PMC_VREG_XCLK_BUF];
            end
            if (state_reg == S_HIB)
                hib_ret_reg <= 1'b1;
            else if (state_reg == S_RUN)
                hib_ret_reg <= 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // wake and power-good pins
    // ------------------------------------------------------------------
    // the pin itself clocks a toggle so a 10 ns level is never missed
    // between two 50 ns samples
    always_ff @(posedge gpio_wake_i or negedge por_n_i)
    begin
        if (!por_n_i)
            wake_tgl_reg <= 1'b0;
        else
            wake_tgl_reg <= !wake_tgl_reg; // RULE8
    end
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wake_sync_reg <= 3'h0;
            pg_sync_reg <= 3'h7;
        end
        else
        begin
            wake_sync_reg <= {wake_sync_reg[1:0], wake_tgl_reg};
            pg_sync_reg <= {pg_sync_reg[1:0], power_good_n_i};
        end
    end
    // a toggle counts once stage two and three agree on its new value
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wake_seen_reg <= 1'b0;
            pg_ok_reg <= 1'b0;
        end
        else
        begin
            if (wake_sync_reg[1] == wake_sync_reg[2])
                wake_seen_reg <= wake_sync_reg[2];
            if (pg_sync_reg[1] == pg_sync_reg[2])
                pg_ok_reg <= !pg_sync_reg[2]; // RULE14
        end
    end
    assign wake_ev = (wake_sync_reg[1] == wake_sync_reg[2])
        && (wake_sync_reg[2] != wake_seen_reg);
    // ------------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= S_PGWAIT;
            mode_reg <= `PMC_M_FULL; // RULE1
            target_reg <= `PMC_M_FULL;
            settle_reg <= 8'h0;
        end
        else
        begin
            unique case (state_reg)
                S_PGWAIT:
                    if (pg_ok_reg || !hib_ret_reg)
                        state_reg <= S_RUN; // RULE14
                S_RUN:
                begin
                    settle_reg <= 8'(SETTLE_CYC);
                    if (!hib_n_reg)
                    begin
                        target_reg <= `PMC_M_HIB; // RULE9
                        state_reg <= S_SWITCH;
                    end
                    // a wake only counts asleep; deep sleep ignores software mode writes
                    else if (wake_ev && (mode_reg == `PMC_M_DEEP
                             || mode_reg == `PMC_M_SLEEP))
                    begin
                        target_reg <= `PMC_M_FULL; // RULE7
                        state_reg <= S_SWITCH;
                    end
                    else if (mode_wr && mode_code_ok
                             && mode_reg != `PMC_M_DEEP)
                    begin
                        target_reg <= mode_wcode; // RULE22
                        state_reg <= S_SWITCH;
                    end
                end
                S_SWITCH:
                    if (settle_reg > 8'h1)
                        settle_reg <= settle_reg - 8'h1;
                    else
                    begin
                        mode_reg <= target_reg; // RULE22
                        state_reg <= (target_reg == `PMC_M_HIB)
                            ? S_HIB : S_RUN;
                    end
                S_HIB:
                    state_reg <= S_HIB; // RULE7
            endcase
        end
    end
    // ------------------------------------------------------------------
    // registered outputs decoded from the applied mode, the state and the setting registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            clk_cfg_o <= '0;
            core_clk_en_o <= 1'b0;
            sys_clk_en_o <= 1'b0;
            dma_l1_allow_o <= 1'b0;
            async_block_o <= 1'b0;
            pins_hiz_o <= 1'b0;
            regulator_wake_out_o <= 1'b1; // RULE12 RULE13
            xclk_buf_sel_o <= 1'b0;
            xclk_oe_n_o <= 1'b1; // RULE21
        end
        else
        begin
            clk_cfg_o.mult <= mult_reg; // RULE16
            clk_cfg_o.sys_div <= ssel_reg; // RULE17 RULE19
            clk_cfg_o.core_div <= 4'h1 << csel_reg; // RULE18 RULE19
            clk_cfg_o.pll_en <= (mode_reg == `PMC_M_FULL)
                || (mode_reg == `PMC_M_ACTIVE)
                || (mode_reg == `PMC_M_SLEEP); // RULE1 RULE4
            clk_cfg_o.pll_bypass <= (mode_reg == `PMC_M_ACTIVE); // RULE2
            core_clk_en_o <= (state_reg != S_PGWAIT)
                && ((mode_reg == `PMC_M_FULL)
                || (mode_reg == `PMC_M_ACTIVE)); // RULE4
            sys_clk_en_o <= (state_reg != S_PGWAIT)
                && ((mode_reg == `PMC_M_FULL)
                || (mode_reg == `PMC_M_ACTIVE)
                || (mode_reg == `PMC_M_SLEEP)); // RULE6
            dma_l1_allow_o <= (mode_reg == `PMC_M_FULL)
                || (mode_reg == `PMC_M_ACTIVE); // RULE3 RULE5
            async_block_o <= (mode_reg == `PMC_M_DEEP)
                || (mode_reg == `PMC_M_HIB); // RULE6
            pins_hiz_o <= (mode_reg == `PMC_M_HIB); // RULE10
            regulator_wake_out_o <= (mode_reg != `PMC_M_HIB); // RULE9
            xclk_buf_sel_o <= xclk_buf_reg; // RULE20
            xclk_oe_n_o <= !xclk_en_reg
                || (mode_reg == `PMC_M_HIB); // RULE21 RULE10
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    AST_ACTIVE_BYPASS: assert property ( // RULE2
        mode_reg == `PMC_M_ACTIVE |=> clk_cfg_o.pll_bypass
            && clk_cfg_o.pll_en)
        else $error("active mode without bypassed pll");
    AST_SLEEP_GATE: assert property ( // RULE4
        mode_reg == `PMC_M_SLEEP |=> !core_clk_en_o && !dma_l1_allow_o
            && clk_cfg_o.pll_en)
        else $error("sleep gating wrong");
    AST_DEEP_GATE: assert property ( // RULE6
        mode_reg == `PMC_M_DEEP |=> !sys_clk_en_o && async_block_o)
        else $error("deep sleep leaves a clock running");
    AST_DEEP_STAYS: assert property ( // RULE7
        state_reg == S_RUN && mode_reg == `PMC_M_DEEP && !wake_ev
            && hib_n_reg |=> state_reg == S_RUN)
        else $error("deep sleep left without wake");
    AST_HIB_PINS: assert property ( // RULE9
        mode_reg == `PMC_M_HIB |=> !regulator_wake_out_o && pins_hiz_o
            && xclk_oe_n_o)
        else $error("hibernate outputs wrong");
    AST_MULT_RANGE: assert property ( // RULE15
        mult_reg >= `PMC_MULT_MIN && mult_reg <= `PMC_MULT_MAX)
        else $error("multiplier out of range");
    AST_DIV_APPLY: assert property ( // RULE19
        bus_wr && avs_address_i == `PMC_OFS_DIV
            |=> ##1 clk_cfg_o.core_div == (4'h1 << $past(csel_reg)))
        else $error("core divider not applied");
    AST_SWITCH_LEN: assert property ( // RULE22
        $rose(state_reg == S_SWITCH) |-> (mode_reg == $past(mode_reg))
            [*2] ##[0:300] state_reg != S_SWITCH)
        else $error("mode switch ran too long");
endmodule

// File: dv/pmc_partner.sv
/*
 * model of the core regulator and of the gpio wake source.
 * assumes: regulator wake drives the regulator's active-low shutdown
 * input directly; the bench raises wake_req_i for one clock per event.
 */
`timescale 1ns/1ps
module pmc_partner #(
    parameter int PG_DLY = 40
)
(
    // clock
    input wire logic mclk_i,
    // regulator
    input wire logic regulator_wake_out_i,
    output logic power_good_n_o,
    // wake source
    input wire logic wake_req_i,
    output logic gpio_wake_o
);
    int cnt;

    initial
    begin
        power_good_n_o = 1'b1;
        gpio_wake_o = 1'b0;
        cnt = 0;
    end

    // ------------------------------------------------------------------
    // regulator: supply drops at once, ramps back slower than a reset
    // ------------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (regulator_wake_out_i !== 1'b1)
        begin
            cnt <= 0;
            power_good_n_o <= 1'b1;
        end
        else if (cnt < PG_DLY)
            cnt <= cnt + 1;
        else
            power_good_n_o <= 1'b0;
    end

    // ------------------------------------------------------------------
    // wake pin: narrower than a clock, off the clock edges
    // ------------------------------------------------------------------
    always @(posedge wake_req_i)
    begin
        #7;
        gpio_wake_o = 1'b1;
        #12;
        gpio_wake_o = 1'b0;
    end
endmodule

// File: dv/tb_top.sv
/*
 * self-checking bench of the power-mode clock controller.
 * assumes: pmc_map.svh on the include path; pmc_partner models the
 * regulator and the wake pin.
 */
`timescale 1ns/1ps
`include "pmc_map.svh"
module tb_top
    import pmc_pkg::*;
;
    logic mclk_i;
    logic rst_n_i;
    logic por_n_i;
    logic [3:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic gpio_wake_i;
    logic power_good_n_i;
    pmc_clk_cfg_t cfg;
    logic core_clk_en_o;
    logic sys_clk_en_o;
    logic dma_l1_allow_o;
    logic async_block_o;
    logic pins_hiz_o;
    logic regulator_wake_out_o;
    logic xclk_buf_sel_o;
    logic xclk_oe_n_o;
    logic wake_req;
    logic [31:0] rd;
    int n_fail;
    int cmp_count;
    int cyc;

    pmc_ctrl i_pmc_ctrl (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .gpio_wake_i(gpio_wake_i), .power_good_n_i(power_good_n_i),
        .clk_cfg_o(cfg), .core_clk_en_o(core_clk_en_o),
        .sys_clk_en_o(sys_clk_en_o), .dma_l1_allow_o(dma_l1_allow_o),
        .async_block_o(async_block_o), .pins_hiz_o(pins_hiz_o),
        .regulator_wake_out_o(regulator_wake_out_o),
        .xclk_buf_sel_o(xclk_buf_sel_o), .xclk_oe_n_o(xclk_oe_n_o)
    );

    pmc_partner i_pmc_partner (
        .mclk_i(mclk_i), .regulator_wake_out_i(regulator_wake_out_o),
        .power_good_n_o(power_good_n_i), .wake_req_i(wake_req),
        .gpio_wake_o(gpio_wake_i)
    );

    // ------------------------------------------------------------------
    // clock, timeout, reporting
    // ------------------------------------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a full run needs a few hundred cycles
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            $display("Error timeout expected run end seen hang");
            final_report();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ------------------------------------------------------------------
    // avalon master: hold the request until waitrequest is seen low
    // ------------------------------------------------------------------
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= 1'b1;
        @(posedge mclk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge mclk_i);
        avs_write_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        @(posedge mclk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge mclk_i);
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask

    task automatic wait_idle;
        bus_rd(`PMC_OFS_MODE, rd);
        while (rd[`PMC_MODE_BUSY] !== 1'b0)
            bus_rd(`PMC_OFS_MODE, rd);
        repeat (2) @(posedge mclk_i);
    endtask

    task automatic gates(input logic [5:0] e);
        check("gates", {26'h0, cfg.pll_en, cfg.pll_bypass, core_clk_en_o,
              sys_clk_en_o, dma_l1_allow_o, async_block_o}, {26'h0, e});
    endtask

    task automatic wake_pulse;
        @(posedge mclk_i);
        wake_req <= 1'b1;
        @(posedge mclk_i);
        wake_req <= 1'b0;
        while (core_clk_en_o !== 1'b1)
            @(posedge mclk_i);
        wait_idle();
        gates(6'b101110);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        gates(6'b101110);
        check("mult", {25'h0, cfg.mult}, {25'h0, `PMC_MULT_RST});
        check("sys_div", {28'h0, cfg.sys_div}, {28'h0, `PMC_SSEL_RST});
        check("xclk_oe_n", {31'h0, xclk_oe_n_o}, 32'h1);
        check("wake", {31'h0, regulator_wake_out_o}, 32'h1);
        bus_rd(4'h2, rd);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_pll;
        logic [31:0] mv [4] = '{32'h5, 32'h40, 32'h4, 32'h41};
        logic [31:0] e;
        for (int i = 0; i < 4; i++)
        begin
            bus_wr(`PMC_OFS_PLL, mv[i]);
            if (mv[i] >= `PMC_MULT_MIN && mv[i] <= `PMC_MULT_MAX)
                e = mv[i];
            repeat (2) @(posedge mclk_i);
            check("mult", {25'h0, cfg.mult}, e);
        end
    endtask

    task automatic t_div;
        int ss [4] = '{1, 2, 10, 15};
        for (int c = 0; c < 4; c++)
        begin
            bus_wr(`PMC_OFS_DIV, {26'h0, 2'(c), 4'(ss[c])});
            repeat (2) @(posedge mclk_i);
            check("sys_div", {28'h0, cfg.sys_div}, 32'(ss[c]));
            check("core_div", {28'h0, cfg.core_div}, 32'(1 << c));
        end
        bus_wr(`PMC_OFS_DIV, 32'h10);
        repeat (2) @(posedge mclk_i);
        check("sys_div", {28'h0, cfg.sys_div}, 32'hf);
        check("core_div", {28'h0, cfg.core_div}, 32'h2);
    endtask

    task automatic t_xclk;
        bus_wr(`PMC_OFS_VREG, 32'h3);
        repeat (2) @(posedge mclk_i);
        check("xclk", {30'h0, xclk_oe_n_o, xclk_buf_sel_o}, 32'h0);
        bus_wr(`PMC_OFS_VREG, 32'h7);
        repeat (2) @(posedge mclk_i);
        check("xclk", {30'h0, xclk_oe_n_o, xclk_buf_sel_o}, 32'h1);
    endtask

    task automatic t_modes;
        bus_wr(`PMC_OFS_MODE, {29'h0, `PMC_M_ACTIVE});
        wait_idle();
        // the regulator has long reported power good by now
        check("mode", rd, {28'h0, 1'b1, `PMC_M_ACTIVE});
        gates(6'b111110);
        bus_wr(`PMC_OFS_MODE, {29'h0, `PMC_M_SLEEP});
        check("early_gate", {31'h0, core_clk_en_o}, 32'h1);
        wait_idle();
        gates(6'b100100);
        wake_pulse();
        bus_wr(`PMC_OFS_MODE, {29'h0, `PMC_M_SLEEP});
        wait_idle();
        bus_wr(`PMC_OFS_MODE, {29'h0, `PMC_M_ACTIVE});
        wait_idle();
        gates(6'b111110);
        bus_wr(`PMC_OFS_MODE, {29'h0, `PMC_M_DEEP});
        wait_idle();
        gates(6'b000001);
        bus_wr(`PMC_OFS_MODE, {29'h0, `PMC_M_FULL});
        repeat (12) @(posedge mclk_i);
        gates(6'b000001);
        wake_pulse();
    endtask

    task automatic t_hib;
        bus_wr(`PMC_OFS_VREG, 32'h6);
        while (pins_hiz_o !== 1'b1)
            @(posedge mclk_i);
        check("hib_wake", {31'h0, regulator_wake_out_o}, 32'h0);
        check("hib_gate", {30'h0, core_clk_en_o, sys_clk_en_o}, 32'h0);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (16) @(posedge mclk_i);
        check("rst_wake", {31'h0, regulator_wake_out_o}, 32'h1);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check("pg_hold", {31'h0, core_clk_en_o}, 32'h0);
        while (core_clk_en_o !== 1'b1)
            @(posedge mclk_i);
        check("pg_seen", {31'h0, power_good_n_i}, 32'h0);
        check("hiz", {31'h0, pins_hiz_o}, 32'h0);
        bus_rd(`PMC_OFS_VREG, rd);
        check("vreg_kept", rd, 32'h7);
        bus_rd(`PMC_OFS_PLL, rd);
        check("mult_lost", rd, {25'h0, `PMC_MULT_RST});
    endtask

    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        rst_n_i = 1'b0;
        // por falls on the first edge so the wake toggle sees its edge
        por_n_i = 1'b1;
        avs_address_i = 4'h0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        wake_req = 1'b0;
        @(posedge mclk_i);
        por_n_i <= 1'b0;
        repeat (15) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        t_reset();
        t_pll();
        t_div();
        t_xclk();
        t_modes();
        t_hib();
        final_report();
    end
endmodule
